// ==== design/crypto_cfg_defs.vh ====
`ifndef CRYPTO_CFG_DEFS_VH
`define CRYPTO_CFG_DEFS_VH

// configuration word indices, byte address is four times the index
`define IDX_W 4
`define IDX_STATUS 4'h0
`define IDX_QUEUE_LIMIT 4'h1
`define IDX_SERVICE 4'h2
`define IDX_CIPHER_LO 4'h3
`define IDX_CIPHER_HI 4'h4
`define IDX_DIGEST 4'h5
`define IDX_AUTH_LO 4'h6
`define IDX_AUTH_HI 4'h7
`define IDX_AEAD 4'h8
`define IDX_CIPHER_KEY 4'h9
`define IDX_AUTH_KEY 4'hA
`define IDX_RESERVED 4'hB
`define IDX_SIZE_LO 4'hC
`define IDX_SIZE_HI 4'hD
`define IDX_LAST 4'hD
`define ADDR_W 6

// service numbers, also bit positions of the service mask
`define SVC_CIPHER 2'h0
`define SVC_DIGEST 2'h1
`define SVC_AUTH 2'h2
`define SVC_AEAD 2'h3

// status word fields
`define READY_BIT 0
`define STATUS_DEFINED 32'h00000001

// bits that carry a defined algorithm code
`define SERVICE_DEFINED 32'h0000000F
`define CIPHER_LO_DEFINED 32'h00007FFE
`define CIPHER_HI_DEFINED 32'h00000000
`define DIGEST_DEFINED 32'h00001FFE
`define AUTH_LO_DEFINED 32'h1E00007E
`define AUTH_HI_DEFINED 32'h00260600
`define AEAD_DEFINED 32'h0000000E

// queue limit field range
`define QUEUE_LIMIT_W 16
`define QUEUE_LIMIT_MIN 16'h0001

// device reset pulse timing
`define CLK_PERIOD_NS 20
`define DEV_RESET_NS 1000

`endif

// ==== design/sync_agree.v ====
`timescale 1ns/100ps
// three-stage synchroniser; output follows once stages two and three agree
module sync_agree #(
  parameter W = 1
) (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer k;

  // stage chain; s1_r feeds only s2_r
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (k = 0; k < W; k = k + 1) begin
        if (s2_r[k] == s3_r[k]) begin
          o_sync[k] <= s3_r[k];
        end
      end
    end
  end
endmodule // sync_agree

// ==== design/crypto_cfg_host.v ====
`timescale 1ns/100ps
`include "crypto_cfg_defs.vh"
// Operation
// - cipher codes 1-14 index cipher mask
// - hash codes 1-12 index digest mask
// - sparse auth codes, above 31 high word
// - authenticated encryption codes 1-3
// - check ready bit, recheck after reset
// - no requests while ready clear
// - oversized request fails, reset device
// - key lengths within their limits
// - read masks only for offered services
// - ignore undefined algorithm mask bits
// - use queues up to reported limit
module crypto_cfg_host #(
  parameter QW = `QUEUE_LIMIT_W
) (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_start,
  input wire i_reset_dev,
  input wire i_req_valid,
  input wire [1:0] i_req_service,
  input wire [5:0] i_req_algo,
  input wire [31:0] i_req_key_len,
  input wire [63:0] i_req_size,
  input wire [QW-1:0] i_req_queue,
  input wire i_cfg_ack,
  input wire [31:0] i_cfg_rdata,
  output reg o_cfg_req,
  output reg [`ADDR_W-1:0] o_cfg_addr,
  output reg o_dev_reset,
  output reg o_busy,
  output reg o_cfg_valid,
  output reg o_ready_flag,
  output reg [QW-1:0] o_queue_limit,
  output reg [3:0] o_service_mask,
  output reg [63:0] o_cipher_mask,
  output reg [31:0] o_digest_mask,
  output reg [63:0] o_auth_mask,
  output reg [31:0] o_aead_mask,
  output reg [31:0] o_cipher_key_limit,
  output reg [31:0] o_auth_key_limit,
  output reg [63:0] o_size_limit,
  output reg o_req_accept,
  output reg o_req_reject,
  output reg o_req_size_fail
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RST = 3'h1;
  localparam [2:0] S_RD = 3'h2;
  localparam [2:0] S_REL = 3'h3;
  localparam [2:0] S_NEXT = 3'h4;
  localparam [2:0] S_DONE = 3'h5;
  localparam integer RST_CYC_I =
    (`DEV_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [7:0] RST_CYC = RST_CYC_I[7:0];

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`IDX_W-1:0] idx_r;
  reg [`IDX_W-1:0] idx_nxt;
  reg [7:0] cnt_r;
  reg [`IDX_W:0] scan;
  reg found;
  reg [13:0] want;
  reg algo_ok;
  reg key_ok;
  reg size_ok;
  reg queue_ok;
  reg [QW-1:0] qlim_w;
  wire ack_s;

  // acknowledge from the device crosses through four flops
  sync_agree #(.W(1)) u_ack_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_async(i_cfg_ack),
    .o_sync(ack_s)
  );

  // words worth reading given the advertised services
  always @* begin
    want = 14'h0000;
    want[`IDX_STATUS] = 1'b1;
    want[`IDX_QUEUE_LIMIT] = 1'b1;
    want[`IDX_SERVICE] = 1'b1;
    want[`IDX_CIPHER_LO] = o_service_mask[`SVC_CIPHER];
    want[`IDX_CIPHER_HI] = o_service_mask[`SVC_CIPHER];
    want[`IDX_DIGEST] = o_service_mask[`SVC_DIGEST];
    want[`IDX_AUTH_LO] = o_service_mask[`SVC_AUTH];
    want[`IDX_AUTH_HI] = o_service_mask[`SVC_AUTH];
    want[`IDX_AEAD] = o_service_mask[`SVC_AEAD];
    want[`IDX_CIPHER_KEY] = o_service_mask[`SVC_CIPHER] |
                            o_service_mask[`SVC_AEAD];
    want[`IDX_AUTH_KEY] = o_service_mask[`SVC_AUTH];
    want[`IDX_RESERVED] = 1'b0;
    want[`IDX_SIZE_LO] = 1'b1;
    want[`IDX_SIZE_HI] = 1'b1;
  end

  // lowest wanted index above the current one
  always @* begin
    idx_nxt = idx_r;
    found = 1'b0;
    for (scan = 5'h00; scan <= {1'b0, `IDX_LAST}; scan = scan + 5'h01) begin
      if (!found && scan > {1'b0, idx_r} && want[scan[3:0]]) begin
        idx_nxt = scan[3:0];
        found = 1'b1;
      end
    end
  end

  // limit never below one even if the device misreports
  always @* begin
    qlim_w = o_queue_limit;
    if (o_queue_limit < `QUEUE_LIMIT_MIN) begin
      qlim_w = `QUEUE_LIMIT_MIN;
    end
  end

  // request checks against discovered capability
  always @* begin
    algo_ok = 1'b0;
    key_ok = 1'b1;
    case (i_req_service)
      `SVC_CIPHER: begin
        algo_ok = o_cipher_mask[i_req_algo];
        key_ok = i_req_key_len <= o_cipher_key_limit;
      end
      `SVC_DIGEST: begin
        algo_ok = (i_req_algo[5] == 1'b0) &&
                  o_digest_mask[i_req_algo[4:0]];
      end
      `SVC_AUTH: begin
        algo_ok = o_auth_mask[i_req_algo];
        key_ok = i_req_key_len <= o_auth_key_limit;
      end
      default: begin
        algo_ok = (i_req_algo[5] == 1'b0) &&
                  o_aead_mask[i_req_algo[4:0]];
        key_ok = i_req_key_len <= o_cipher_key_limit;
      end
    endcase
    algo_ok = algo_ok && o_service_mask[i_req_service];
    size_ok = i_req_size <= o_size_limit;
    queue_ok = i_req_queue < qlim_w;
  end

  // next state of the discovery sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (i_reset_dev) begin
          state_nxt = S_RST;
        end else if (i_start) begin
          state_nxt = S_RD;
        end
      end
      S_RST: begin
        if (cnt_r == RST_CYC && !ack_s) begin
          state_nxt = S_RD;
        end
      end
      S_RD: begin
        if (ack_s) begin
          state_nxt = S_REL;
        end
      end
      S_REL: begin
        if (!ack_s) begin
          state_nxt = S_NEXT;
        end
      end
      S_NEXT: begin
        if (!o_ready_flag) begin
          state_nxt = S_RD;
        end else if (idx_r == `IDX_SIZE_HI) begin
          state_nxt = S_DONE;
        end else begin
          state_nxt = S_RD;
        end
      end
      S_DONE: begin
        if (i_reset_dev) begin
          state_nxt = S_RST;
        end else if (i_start) begin
          state_nxt = S_RD;
        end else if (i_req_valid && o_ready_flag && !size_ok) begin
          state_nxt = S_RST;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // sequencer registers, read strobe and captured words
  always @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state_r <= S_IDLE;
      idx_r <= `IDX_STATUS;
      cnt_r <= 8'h00;
      o_cfg_req <= 1'b0;
      o_cfg_addr <= {`ADDR_W{1'b0}};
      o_dev_reset <= 1'b0;
      o_busy <= 1'b0;
      o_cfg_valid <= 1'b0;
      o_ready_flag <= 1'b0;
      o_queue_limit <= {QW{1'b0}};
      o_service_mask <= 4'h0;
      o_cipher_mask <= 64'h0000000000000000;
      o_digest_mask <= 32'h00000000;
      o_auth_mask <= 64'h0000000000000000;
      o_aead_mask <= 32'h00000000;
      o_cipher_key_limit <= 32'h00000000;
      o_auth_key_limit <= 32'h00000000;
      o_size_limit <= 64'h0000000000000000;
      o_req_accept <= 1'b0;
      o_req_reject <= 1'b0;
      o_req_size_fail <= 1'b0;
    end else begin
      state_r <= state_nxt;
      o_req_accept <= 1'b0;
      o_req_reject <= 1'b0;
      o_req_size_fail <= 1'b0;
      o_busy <= (state_nxt != S_IDLE) && (state_nxt != S_DONE);
      o_dev_reset <= (state_nxt == S_RST);
      o_cfg_req <= (state_nxt == S_RD);
      cnt_r <= (state_nxt == S_RST && cnt_r != RST_CYC) ?
               cnt_r + 8'h01 : 8'h00;
      // a fresh discovery forgets all learned before except queue and size limits
      if ((state_r == S_IDLE || state_r == S_DONE || state_r == S_RST) &&
          state_nxt != state_r) begin
        idx_r <= `IDX_STATUS;
        o_cfg_addr <= {`IDX_STATUS, 2'b00};
        o_cfg_valid <= 1'b0;
        o_ready_flag <= 1'b0;
        o_service_mask <= 4'h0;
        o_cipher_mask <= 64'h0000000000000000;
        o_digest_mask <= 32'h00000000;
        o_auth_mask <= 64'h0000000000000000;
        o_aead_mask <= 32'h00000000;
        o_cipher_key_limit <= 32'h00000000;
        o_auth_key_limit <= 32'h00000000;
      end
      // capture the word while the device holds it under acknowledge
      if (state_r == S_RD && ack_s) begin
        case (idx_r)
          `IDX_STATUS: begin
            o_ready_flag <= i_cfg_rdata[`READY_BIT] &
                            ((i_cfg_rdata & ~`STATUS_DEFINED) ==
                             32'h00000000);
          end
          `IDX_QUEUE_LIMIT: begin
            o_queue_limit <= i_cfg_rdata[QW-1:0];
          end
          `IDX_SERVICE: begin
            o_service_mask <= i_cfg_rdata[3:0];
          end
          `IDX_CIPHER_LO: begin
            o_cipher_mask[31:0] <= i_cfg_rdata & `CIPHER_LO_DEFINED;
          end
          `IDX_CIPHER_HI: begin
            o_cipher_mask[63:32] <= i_cfg_rdata & `CIPHER_HI_DEFINED;
          end
          `IDX_DIGEST: begin
            o_digest_mask <= i_cfg_rdata & `DIGEST_DEFINED;
          end
          `IDX_AUTH_LO: begin
            o_auth_mask[31:0] <= i_cfg_rdata & `AUTH_LO_DEFINED;
          end
          `IDX_AUTH_HI: begin
            o_auth_mask[63:32] <= i_cfg_rdata & `AUTH_HI_DEFINED;
          end
          `IDX_AEAD: begin
            o_aead_mask <= i_cfg_rdata & `AEAD_DEFINED;
          end
          `IDX_CIPHER_KEY: begin
            o_cipher_key_limit <= i_cfg_rdata;
          end
          `IDX_AUTH_KEY: begin
            o_auth_key_limit <= i_cfg_rdata;
          end
          `IDX_SIZE_LO: begin
            o_size_limit[31:0] <= i_cfg_rdata;
          end
          default: begin
            o_size_limit[63:32] <= i_cfg_rdata;
          end
        endcase
      end
      // step to the next wanted word, or poll status until ready
      if (state_r == S_NEXT) begin
        if (!o_ready_flag) begin
          idx_r <= `IDX_STATUS;
          o_cfg_addr <= {`IDX_STATUS, 2'b00};
        end else if (idx_r == `IDX_SIZE_HI) begin
          o_cfg_valid <= 1'b1;
        end else begin
          idx_r <= idx_nxt;
          o_cfg_addr <= {idx_nxt, 2'b00};
        end
      end
      // gate user requests on ready flag and reported limits
      if (state_r == S_DONE && i_req_valid && !i_reset_dev && !i_start) begin
        if (o_ready_flag && algo_ok && key_ok && size_ok && queue_ok) begin
          o_req_accept <= 1'b1;
        end else begin
          o_req_reject <= 1'b1;
          o_req_size_fail <= o_ready_flag & ~size_ok;
        end
      end
    end
  end
endmodule // crypto_cfg_host

// ==== tb/crypto_cfg_props.sv ====
`timescale 1ns/100ps
`include "crypto_cfg_defs.vh"
// checks on discovery reads and request gating
module crypto_cfg_props (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_req_valid,
  input wire i_cfg_ack,
  input wire o_cfg_req,
  input wire [`ADDR_W-1:0] o_cfg_addr,
  input wire o_dev_reset,
  input wire o_busy,
  input wire o_cfg_valid,
  input wire o_ready_flag,
  input wire [3:0] o_service_mask,
  input wire [63:0] o_cipher_mask,
  input wire [31:0] o_digest_mask,
  input wire [63:0] o_auth_mask,
  input wire [31:0] o_aead_mask,
  input wire o_req_accept,
  input wire o_req_reject,
  input wire o_req_size_fail
);
  reg [7:0] rst_cnt_r;
  // length of the device reset pulse so far
  always @(posedge i_sys_clk)
    rst_cnt_r <= o_dev_reset ? rst_cnt_r + 8'h01 : 8'h00;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // device answer seen for three samples
  sequence s_ack_held;
    i_cfg_ack [*3];
  endsequence
  // refusal followed closely by a device reset
  sequence s_reject_reset;
    o_req_reject ##[0:3] o_dev_reset;
  endsequence
  chk_req_drop: assert property (s_ack_held ##0 o_cfg_req |->
    ##[1:4] !o_cfg_req) else $error("request held after ack");
  chk_req_gap: assert property ($rose(o_cfg_req) |->
    !$past(i_cfg_ack) && !$past(i_cfg_ack, 3))
    else $error("request too soon");
  chk_addr_hold: assert property (o_cfg_req && $past(o_cfg_req) |->
    $stable(o_cfg_addr)) else $error("address moved");
  chk_no_reserved: assert property (o_cfg_req |->
    o_cfg_addr != 6'h2C && o_cfg_addr <= 6'h34) else $error("bad address");
  chk_mask_clean: assert property (o_cfg_valid |->
    ((o_cipher_mask & ~{`CIPHER_HI_DEFINED, `CIPHER_LO_DEFINED}) == 64'h0)
    && ((o_auth_mask & ~{`AUTH_HI_DEFINED, `AUTH_LO_DEFINED}) == 64'h0)
    && ((o_digest_mask & ~`DIGEST_DEFINED) == 32'h0)
    && ((o_aead_mask & ~`AEAD_DEFINED) == 32'h0)) else $error("stray bit");
  chk_unoffered_zero: assert property (o_cfg_valid |->
    (o_service_mask[0] || o_cipher_mask == 64'h0)
    && (o_service_mask[1] || o_digest_mask == 32'h0)
    && (o_service_mask[2] || o_auth_mask == 64'h0)
    && (o_service_mask[3] || o_aead_mask == 32'h0))
    else $error("mask of absent service");
  chk_accept_ready: assert property (o_req_accept |->
    o_ready_flag && o_cfg_valid && !o_req_reject && $past(i_req_valid))
    else $error("accept without cause");
  chk_size_reset: assert property (o_req_size_fail |-> s_reject_reset)
    else $error("no reset after size fail");
  chk_reset_len: assert property ($fell(o_dev_reset) |->
    rst_cnt_r == 8'h32) else $error("reset pulse length");
  chk_valid_ready: assert property ($rose(o_cfg_valid) |->
    o_ready_flag && !o_busy) else $error("valid while not ready");
endmodule // crypto_cfg_props
bind crypto_cfg_host crypto_cfg_props u_props (.i_sys_clk, .i_rstn,
  .i_req_valid, .i_cfg_ack, .o_cfg_req, .o_cfg_addr, .o_dev_reset, .o_busy,
  .o_cfg_valid, .o_ready_flag, .o_service_mask, .o_cipher_mask,
  .o_digest_mask, .o_auth_mask, .o_aead_mask, .o_req_accept,
  .o_req_reject, .o_req_size_fail);

// ==== tb/crypto_dev_model.sv ====
`timescale 1ns/100ps
// behavioural config space with a four-phase read answer
module crypto_dev_model (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_cfg_req,
  input wire [5:0] i_cfg_addr,
  input wire i_dev_reset,
  input wire [31:0] i_status,
  input wire [3:0] i_services,
  input wire i_bad_bits,
  input wire i_slow,
  output reg o_cfg_ack,
  output reg [31:0] o_cfg_rdata
);
  reg [31:0] word_nxt;
  reg [3:0] wait_r;
  // word table; masks only for offered services, stray bits on command
  always @* begin
    case (i_cfg_addr[5:2])
      4'h0: word_nxt = i_status;
      4'h1: word_nxt = 32'h00000004;
      4'h2: word_nxt = {28'h0, i_services};
      4'h3: word_nxt = i_services[0] ? 32'h0000000A : 32'h0;
      4'h5: word_nxt = i_services[1] ? 32'h00001002 : 32'h0;
      4'h6: word_nxt = i_services[2] ? 32'h02000004 : 32'h0;
      4'h7: word_nxt = i_services[2] ? 32'h00200200 : 32'h0;
      4'h8: word_nxt = i_services[3] ? 32'h00000008 : 32'h0;
      4'h9: word_nxt = 32'h00000020;
      4'hA: word_nxt = 32'h00000040;
      4'hC: word_nxt = 32'h00000100;
      default: word_nxt = 32'h0;
    endcase
    if (i_bad_bits && i_cfg_addr[5:2] >= 4'h3 && i_cfg_addr[5:2] <= 4'h8)
      word_nxt = word_nxt | 32'h80000001;
  end
  // data settles before ack; released data shows its inverse
  always @(posedge i_sys_clk) begin
    if (!i_rstn || i_dev_reset) begin
      o_cfg_ack <= 1'b0;
      wait_r <= 4'h0;
    end else if (i_cfg_req && !o_cfg_ack) begin
      o_cfg_rdata <= word_nxt;
      wait_r <= wait_r + 4'h1;
      if (wait_r == (i_slow ? 4'hC : 4'h3))
        o_cfg_ack <= 1'b1;
    end else if (!i_cfg_req && o_cfg_ack) begin
      o_cfg_ack <= 1'b0;
      o_cfg_rdata <= ~o_cfg_rdata;
      wait_r <= 4'h0;
    end
  end
endmodule // crypto_dev_model

// ==== tb/crypto_cfg_host_tb.sv ====
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks = total_checks + 1; \
  if ((s) !== (e)) begin fails = fails + 1; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
// discovery and request gating against the device model
module crypto_cfg_host_tb;
  reg i_sys_clk, i_rstn, i_start, i_reset_dev, i_req_valid, bad, slow;
  reg [1:0] i_req_service;
  reg [5:0] i_req_algo;
  reg [31:0] i_req_key_len, sts;
  reg [63:0] i_req_size;
  reg [15:0] i_req_queue;
  reg [3:0] svc;
  wire i_cfg_ack, o_cfg_req, o_dev_reset, o_busy, o_cfg_valid, o_ready_flag;
  wire o_req_accept, o_req_reject, o_req_size_fail;
  wire [5:0] o_cfg_addr;
  wire [3:0] o_service_mask;
  wire [15:0] o_queue_limit;
  wire [31:0] i_cfg_rdata, o_digest_mask, o_aead_mask;
  wire [31:0] o_cipher_key_limit, o_auth_key_limit;
  wire [63:0] o_cipher_mask, o_auth_mask, o_size_limit;
  integer fails, total_checks, cyc;
  crypto_cfg_host u_dut (.i_sys_clk, .i_rstn, .i_start, .i_reset_dev,
    .i_req_valid, .i_req_service, .i_req_algo, .i_req_key_len, .i_req_size,
    .i_req_queue, .i_cfg_ack, .i_cfg_rdata, .o_cfg_req, .o_cfg_addr,
    .o_dev_reset, .o_busy, .o_cfg_valid, .o_ready_flag, .o_queue_limit,
    .o_service_mask, .o_cipher_mask, .o_digest_mask, .o_auth_mask,
    .o_aead_mask, .o_cipher_key_limit, .o_auth_key_limit, .o_size_limit,
    .o_req_accept, .o_req_reject, .o_req_size_fail);
  crypto_dev_model u_dev (.i_sys_clk, .i_rstn, .i_cfg_req(o_cfg_req),
    .i_cfg_addr(o_cfg_addr), .i_dev_reset(o_dev_reset), .i_status(sts),
    .i_services(svc), .i_bad_bits(bad), .i_slow(slow),
    .o_cfg_ack(i_cfg_ack), .o_cfg_rdata(i_cfg_rdata));
  // 20 ns clock
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // ceiling far above the roughly 1500 cycles the tests take
  always @(posedge i_sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      test_done;
    end
  end
  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // one-cycle start or device reset order
  task kick(input rd);
    begin
      if (rd)
        i_reset_dev = 1'b1;
      else
        i_start = 1'b1;
      @(negedge i_sys_clk);
      i_reset_dev = 1'b0;
      i_start = 1'b0;
    end
  endtask
  task wait_valid;
    integer n;
    begin
      for (n = 0; n < 8 && o_busy !== 1'b1; n = n + 1)
        @(negedge i_sys_clk);
      for (n = 0; n < 3000 && o_cfg_valid !== 1'b1; n = n + 1)
        @(negedge i_sys_clk);
      `CHK("cfg_valid", 1'b1, o_cfg_valid)
    end
  endtask
  // request held for one edge, verdict read one cycle later
  task req(input [1:0] s, input [5:0] a, input [31:0] k,
    input [63:0] z, input [15:0] q, input ok);
    begin
      i_req_service = s;
      i_req_algo = a;
      i_req_key_len = k;
      i_req_size = z;
      i_req_queue = q;
      i_req_valid = 1'b1;
      @(negedge i_sys_clk);
      `CHK("accept", ok, o_req_accept)
      `CHK("reject", !ok, o_req_reject)
    end
  endtask
  initial begin
    fails = 0;
    total_checks = 0;
    cyc = 0;
    i_rstn = 1'b0;
    i_start = 1'b0;
    i_reset_dev = 1'b0;
    i_req_valid = 1'b0;
    i_req_service = 2'h0;
    i_req_algo = 6'h0;
    i_req_key_len = 32'h0;
    i_req_size = 64'h0;
    i_req_queue = 16'h0;
    sts = 32'h1;
    svc = 4'hF;
    bad = 1'b0;
    slow = 1'b0;
    repeat (20) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    kick(1'b0);
    wait_valid;
    `CHK("queues", 16'h0004, o_queue_limit)
    `CHK("services", 4'hF, o_service_mask)
    `CHK("cipher", 64'hA, o_cipher_mask)
    `CHK("digest", 32'h1002, o_digest_mask)
    `CHK("auth", 64'h00200200_02000004, o_auth_mask)
    `CHK("aead", 32'h8, o_aead_mask)
    `CHK("cipher_key", 32'h20, o_cipher_key_limit)
    `CHK("auth_key", 32'h40, o_auth_key_limit)
    `CHK("size", 64'h100, o_size_limit)
    req(2'h0, 6'h03, 32'h20, 64'h100, 16'h3, 1'b1);
    req(2'h0, 6'h02, 32'h1, 64'h1, 16'h0, 1'b0);
    req(2'h0, 6'h01, 32'h21, 64'h1, 16'h0, 1'b0);
    req(2'h1, 6'h0C, 32'h63, 64'h1, 16'h0, 1'b1);
    req(2'h1, 6'h00, 32'h0, 64'h1, 16'h0, 1'b0);
    req(2'h2, 6'h29, 32'h40, 64'h1, 16'h0, 1'b1);
    req(2'h2, 6'h35, 32'h41, 64'h1, 16'h0, 1'b0);
    req(2'h3, 6'h03, 32'h21, 64'h1, 16'h0, 1'b0);
    req(2'h0, 6'h03, 32'h1, 64'h1, 16'h4, 1'b0);
    req(2'h0, 6'h03, 32'h1, 64'h101, 16'h0, 1'b0);
    `CHK("size_fail", 1'b1, o_req_size_fail)
    i_req_valid = 1'b0;
    wait_valid;
    $display("test full_device done");
    svc = 4'h5;
    bad = 1'b1;
    slow = 1'b1;
    kick(1'b0);
    wait_valid;
    `CHK("cipher", 64'hA, o_cipher_mask)
    `CHK("auth", 64'h00200200_02000004, o_auth_mask)
    `CHK("digest", 32'h0, o_digest_mask)
    `CHK("aead", 32'h0, o_aead_mask)
    req(2'h1, 6'h01, 32'h0, 64'h1, 16'h0, 1'b0);
    i_req_valid = 1'b0;
    $display("test partial_device done");
    sts = 32'h3;
    kick(1'b1);
    repeat (300) @(negedge i_sys_clk);
    `CHK("polling", 2'h1, {o_cfg_valid, o_busy})
    `CHK("ready", 1'b0, o_ready_flag)
    sts = 32'h1;
    wait_valid;
    `CHK("ready", 1'b1, o_ready_flag)
    req(2'h0, 6'h01, 32'h20, 64'h1, 16'h0, 1'b1);
    i_req_valid = 1'b0;
    $display("test ready_poll done");
    test_done;
  end
endmodule // crypto_cfg_host_tb
